// ===== fhbi_consts.vh
// Constants shared by the host bus interface of the disk controller.
// Assumes inclusion by bare name from every design file of the block.
`ifndef FHBI_CONSTS_VH
`define FHBI_CONSTS_VH

// ---------------------------------------------------------------
// Register select codes
// ---------------------------------------------------------------
`define FHBI_RS_STATUS      1'b0
`define FHBI_RS_DATA        1'b1

// ---------------------------------------------------------------
// Bus style strap levels
// ---------------------------------------------------------------
`define FHBI_STYLE_STROBE   1'b0
`define FHBI_STYLE_ECLK     1'b1

// ---------------------------------------------------------------
// Interrupt cause bit positions and field width
// ---------------------------------------------------------------
`define FHBI_CAUSE_XFER     0
`define FHBI_CAUSE_RESULT   1
`define FHBI_CAUSE_SEEK     2
`define FHBI_CAUSE_READY    3
`define FHBI_CAUSE_W        4

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define FHBI_SYNC_RST       1'b1
`define FHBI_READY_RST      1'b0
`define FHBI_DATA_RST       8'h00
`define FHBI_CAUSE_RST      4'h0

`endif

// ===== fhbi_sync.v
// Two-stage synchroniser for a group of asynchronous pins.
// Assumes each bit is a level that stays put for several clock cycles.
`timescale 1ns/1ps

module fhbi_sync #(
    parameter WIDTH = 16
) (
    input  wire             clk,
    input  wire             rstn,
    input  wire [WIDTH-1:0] asyncIn,
    output wire [WIDTH-1:0] syncOut
);

`include "fhbi_consts.vh"

// ---------------------------------------------------------------
// Per-bit chain
// ---------------------------------------------------------------
genvar gi;
generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : gBit
        reg firstStage;
        reg secondStage;
        // Only the second stage is ever read, so a metastable first
        // stage has a full cycle to settle
        always @(posedge clk) begin
            if (!rstn) begin
                firstStage  <= `FHBI_SYNC_RST;
                secondStage <= `FHBI_SYNC_RST;
            end else begin
                firstStage  <= asyncIn[gi];
                secondStage <= firstStage;
            end
        end
        assign syncOut[gi] = secondStage;
    end
endgenerate

endmodule

// ===== fhbi_ready_watch.v
// Remembers each drive's ready level as seen at its last poll and
// pulses when a new poll sees a different level.
// Assumes pollStrobe and pollDrive come from the same clock domain.
`timescale 1ns/1ps

module fhbi_ready_watch #(
    parameter DRIVES = 4,
    parameter SEL_W  = 2
) (
    input  wire             clk,
    input  wire             rstn,
    input  wire             pollStrobe,
    input  wire [SEL_W-1:0] pollDrive,
    input  wire             readyLevel,
    output reg              readyChange
);

`include "fhbi_consts.vh"

wire [DRIVES-1:0] hit;

// ---------------------------------------------------------------
// Per-drive memory of the last polled level
// ---------------------------------------------------------------
genvar gd;
generate
    for (gd = 0; gd < DRIVES; gd = gd + 1) begin : gDrive
        reg lastReady;
        always @(posedge clk) begin
            if (!rstn) begin
                lastReady <= `FHBI_READY_RST;
            end else if (pollStrobe && pollDrive == gd) begin
                lastReady <= readyLevel;
            end
        end
        assign hit[gd] = pollStrobe && pollDrive == gd && lastReady != readyLevel;
    end
endgenerate

always @(posedge clk) begin
    if (!rstn) begin
        readyChange <= 1'b0;
    end else begin
        readyChange <= |hit;
    end
end

endmodule

// ===== fhbi_host_port.v
// Host bus interface and interrupt logic of the disk controller.
// Assumes host pins are asynchronous and the command core runs on clk.
//
// Behaviour
// - Three states: idle, sleep, executing
// - Interrupt requests each programmed-transfer data byte
// - Interrupt on read/write end for result bytes
// - Interrupt when head seek or homing ends
// - Interrupt when polled drive ready level changed
// - Strap low selects strobe-style host bus
// - Strap high selects E-clock host bus
// - Strobe style: strobes time every register access
// - Strobe style: write captured at strobe rise
// - Late chip select only delays read data
// - Grant input selects data path without address
// - Active grant replaces chip select in DMA
// - E-clock style: interrupt pin is open-drain
// - E-clock style: direction inverts in DMA accesses
// - E-clock style: E clock times every access
// - E rise samples direction, select, register select
// - DMA uses E timing, grant acts as select
`timescale 1ns/1ps

module fhbi_host_port #(
    parameter DRIVES = 4,
    parameter SEL_W  = 2
) (
    input  wire             clk,
    input  wire             rstn,
    input  wire             busStyleSelect,
    input  wire             chipSelectN,
    input  wire             registerSelect,
    input  wire             readStrobeN,
    input  wire             writeStrobeN,
    input  wire             eClock,
    input  wire             rwDirection,
    input  wire             transferGrantN,
    input  wire [7:0]       hostDataIn,
    output reg  [7:0]       hostDataOut,
    output reg              hostDataOe,
    output reg              irqNOut,
    output reg              irqOe,
    input  wire             readyIn,
    input  wire [7:0]       statusByte,
    input  wire [7:0]       readByte,
    output reg              regWrite,
    output reg              regWriteSel,
    output reg  [7:0]       writeByte,
    output reg              regRead,
    output reg              regReadSel,
    output reg              dmaAccess,
    input  wire             programmedTransfer,
    input  wire             byteRequest,
    input  wire             rwTerminate,
    input  wire             seekDone,
    input  wire             pollStrobe,
    input  wire [SEL_W-1:0] pollDrive,
    input  wire             causeAck,
    input  wire             sleepCmd,
    input  wire             cmdStart,
    input  wire             cmdDone,
    output reg  [2:0]       opState,
    output reg  [3:0]       irqCause,
    output reg              eClockStyle
);

`include "fhbi_consts.vh"

localparam ST_IDLE  = 3'b001;
localparam ST_SLEEP = 3'b010;
localparam ST_EXEC  = 3'b100;

// ---------------------------------------------------------------
// Pin synchronisation
// ---------------------------------------------------------------
wire [16:0] pinsAsync;
wire [16:0] pinsSync;

assign pinsAsync = {readyIn, busStyleSelect, transferGrantN, rwDirection,
                    eClock, writeStrobeN, readStrobeN, registerSelect,
                    chipSelectN, hostDataIn};

fhbi_sync #(
    .WIDTH   (17)
) uSync (
    .clk     (clk),
    .rstn    (rstn),
    .asyncIn (pinsAsync),
    .syncOut (pinsSync)
);

wire [7:0] sData;
wire       sCsN;
wire       sRs;
wire       sRdN;
wire       sWrN;
wire       sE;
wire       sRw;
wire       sGrantN;
wire       sStyle;
wire       sReady;

assign sData   = pinsSync[7:0];
assign sCsN    = pinsSync[8];
assign sRs     = pinsSync[9];
assign sRdN    = pinsSync[10];
assign sWrN    = pinsSync[11];
assign sE      = pinsSync[12];
assign sRw     = pinsSync[13];
assign sGrantN = pinsSync[14];
assign sStyle  = pinsSync[15];
// Ready level of the polled drive; the mux sits outside the block,
// so a poll right after a drive change may still see the old level
assign sReady  = pinsSync[16];

// ---------------------------------------------------------------
// Selection and edge history
// ---------------------------------------------------------------
// A grant stands in for chip select and always means the data path
wire selDma;
wire selAny;

assign selDma = ~sGrantN;
assign selAny = ~sCsN | selDma;

reg rdPrevN;
reg wrPrevN;
reg ePrev;

always @(posedge clk) begin
    if (!rstn) begin
        rdPrevN <= `FHBI_SYNC_RST;
        wrPrevN <= `FHBI_SYNC_RST;
        ePrev   <= 1'b0;
    end else begin
        rdPrevN <= sRdN;
        wrPrevN <= sWrN;
        ePrev   <= sE;
    end
end

wire rdRise;
wire wrRise;
wire eRise;
wire eFall;

assign rdRise = ~rdPrevN & sRdN;
assign wrRise = ~wrPrevN & sWrN;
assign eRise  = ~ePrev & sE;
assign eFall  = ePrev & ~sE;

// Strap is taken after reset release, never under reset itself
always @(posedge clk) begin
    if (!rstn) begin
        eClockStyle <= `FHBI_STYLE_STROBE;
    end else begin
        eClockStyle <= sStyle;
    end
end

// ---------------------------------------------------------------
// Strobe-style access tracking
// ---------------------------------------------------------------
reg       rdHit;
reg       rdDma;
reg       rdRs;
reg       wrHit;
reg       wrDma;
reg       wrRs;
reg [7:0] wrData;

always @(posedge clk) begin
    if (!rstn) begin
        rdHit  <= 1'b0;
        rdDma  <= 1'b0;
        rdRs   <= `FHBI_RS_STATUS;
        wrHit  <= 1'b0;
        wrDma  <= 1'b0;
        wrRs   <= `FHBI_RS_STATUS;
        wrData <= `FHBI_DATA_RST;
    end else begin
        // Select may arrive after the strobe; it is re-checked every
        // cycle of the low phase, so a late select only delays data
        if (!sRdN) begin
            rdHit <= selAny;
            rdDma <= selDma;
            rdRs  <= sRs;
        end else begin
            rdHit <= 1'b0;
        end
        // Track the last low-phase values so the rise commits them
        if (!sWrN) begin
            wrHit  <= selAny;
            wrDma  <= selDma;
            wrRs   <= sRs;
            wrData <= sData;
        end
    end
end

// ---------------------------------------------------------------
// E-clock style access tracking
// ---------------------------------------------------------------
reg eAcc;
reg eDma;
reg eRead;
reg eRs;

always @(posedge clk) begin
    if (!rstn) begin
        eAcc  <= 1'b0;
        eDma  <= 1'b0;
        eRead <= 1'b0;
        eRs   <= `FHBI_RS_STATUS;
    end else if (eRise) begin
        eAcc  <= selAny;
        eDma  <= selDma;
        eRead <= selDma ? ~sRw : sRw;
        eRs   <= sRs;
    end else if (eFall) begin
        eAcc  <= 1'b0;
    end
end

// ---------------------------------------------------------------
// Access pulses towards the command core
// ---------------------------------------------------------------
reg       next_regWrite;
reg       next_regWriteSel;
reg [7:0] next_writeByte;
reg       next_regRead;
reg       next_regReadSel;
reg       next_dmaAccess;

always @* begin
    next_regWrite    = 1'b0;
    next_regWriteSel = `FHBI_RS_STATUS;
    next_writeByte   = writeByte;
    next_regRead     = 1'b0;
    next_regReadSel  = `FHBI_RS_STATUS;
    next_dmaAccess   = 1'b0;
    if (eClockStyle == `FHBI_STYLE_STROBE) begin
        if (wrRise && wrHit) begin
            next_regWrite    = 1'b1;
            next_regWriteSel = wrDma ? `FHBI_RS_DATA : wrRs;
            next_writeByte   = wrData;
            next_dmaAccess   = wrDma;
        end
        if (rdRise && rdHit) begin
            next_regRead    = 1'b1;
            next_regReadSel = rdDma ? `FHBI_RS_DATA : rdRs;
            next_dmaAccess  = rdDma;
        end
    end else if (eFall && eAcc) begin
        // Write data is taken from the first synchronised sample after E falls
        next_regWrite    = ~eRead;
        next_regRead     = eRead;
        next_regWriteSel = eDma ? `FHBI_RS_DATA : eRs;
        next_regReadSel  = eDma ? `FHBI_RS_DATA : eRs;
        next_writeByte   = eRead ? writeByte : sData;
        next_dmaAccess   = eDma;
    end
end

always @(posedge clk) begin
    if (!rstn) begin
        regWrite    <= 1'b0;
        regWriteSel <= `FHBI_RS_STATUS;
        writeByte   <= `FHBI_DATA_RST;
        regRead     <= 1'b0;
        regReadSel  <= `FHBI_RS_STATUS;
        dmaAccess   <= 1'b0;
    end else begin
        regWrite    <= next_regWrite;
        regWriteSel <= next_regWriteSel;
        writeByte   <= next_writeByte;
        regRead     <= next_regRead;
        regReadSel  <= next_regReadSel;
        dmaAccess   <= next_dmaAccess;
    end
end

// ---------------------------------------------------------------
// Read data drive
// ---------------------------------------------------------------
wire driveStrobe;
wire driveE;
wire driveSel;

assign driveStrobe = (eClockStyle == `FHBI_STYLE_STROBE) && rdHit && !sRdN;
assign driveE      = (eClockStyle == `FHBI_STYLE_ECLK) && eAcc && eRead && sE;
assign driveSel    = driveStrobe ? (rdDma | rdRs) : (eDma | eRs);

always @(posedge clk) begin
    if (!rstn) begin
        hostDataOut <= `FHBI_DATA_RST;
        hostDataOe  <= 1'b0;
    end else begin
        hostDataOe  <= driveStrobe | driveE;
        hostDataOut <= (driveSel == `FHBI_RS_DATA) ? readByte : statusByte;
    end
end

// ---------------------------------------------------------------
// Operating state
// ---------------------------------------------------------------
always @(posedge clk) begin
    if (!rstn) begin
        opState <= ST_IDLE;
    end else begin
        case (opState)
            ST_IDLE: begin
                if (cmdStart) begin
                    opState <= ST_EXEC;
                end else if (sleepCmd) begin
                    opState <= ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                // Sleep still waits for commands
                if (cmdStart) begin
                    opState <= ST_EXEC;
                end
            end
            ST_EXEC: begin
                if (cmdDone) begin
                    opState <= ST_IDLE;
                end
            end
            default: begin
                opState <= ST_IDLE;
            end
        endcase
    end
end

// ---------------------------------------------------------------
// Interrupt causes
// ---------------------------------------------------------------
wire readyChange;

fhbi_ready_watch #(
    .DRIVES      (DRIVES),
    .SEL_W       (SEL_W)
) uReady (
    .clk         (clk),
    .rstn        (rstn),
    .pollStrobe  (pollStrobe),
    .pollDrive   (pollDrive),
    .readyLevel  (sReady),
    .readyChange (readyChange)
);

wire dataTouched;
wire dataReadDone;
wire [3:0] causeSet;
wire [3:0] causeClr;

assign dataTouched  = (regRead && regReadSel == `FHBI_RS_DATA) ||
                      (regWrite && regWriteSel == `FHBI_RS_DATA);
assign dataReadDone = regRead && regReadSel == `FHBI_RS_DATA;

assign causeSet[`FHBI_CAUSE_XFER]   = programmedTransfer & byteRequest;
assign causeSet[`FHBI_CAUSE_RESULT] = rwTerminate;
assign causeSet[`FHBI_CAUSE_SEEK]   = seekDone;
assign causeSet[`FHBI_CAUSE_READY]  = readyChange;

assign causeClr[`FHBI_CAUSE_XFER]   = dataTouched;
assign causeClr[`FHBI_CAUSE_RESULT] = dataReadDone;
assign causeClr[`FHBI_CAUSE_SEEK]   = causeAck;
assign causeClr[`FHBI_CAUSE_READY]  = causeAck;

// A new event in the clearing cycle survives the clear
always @(posedge clk) begin
    if (!rstn) begin
        irqCause <= `FHBI_CAUSE_RST;
    end else begin
        irqCause <= causeSet | (irqCause & ~causeClr);
    end
end

// ---------------------------------------------------------------
// Interrupt pin
// ---------------------------------------------------------------
// irqCause is also offered to the core so that the status byte it
// returns tells the host which cause is pending
always @(posedge clk) begin
    if (!rstn) begin
        irqNOut <= 1'b1;
        irqOe   <= 1'b0;
    end else if (eClockStyle == `FHBI_STYLE_ECLK) begin
        irqNOut <= 1'b0;
        irqOe   <= |irqCause;
    end else begin
        irqNOut <= ~(|irqCause);
        irqOe   <= 1'b1;
    end
end

endmodule

// ===== fhbi_host_port_properties.sv
// Concurrent checks on the host port pins and interrupt flags.
// Assumes host pins change just after clk edges, never on them.
`timescale 1ns/1ps

module fhbi_host_port_properties (
    input wire       clk,
    input wire       rstn,
    input wire       chipSelectN,
    input wire       writeStrobeN,
    input wire       eClock,
    input wire       rwDirection,
    input wire       transferGrantN,
    input wire       hostDataOe,
    input wire       irqNOut,
    input wire       irqOe,
    input wire       regWrite,
    input wire       regWriteSel,
    input wire       regRead,
    input wire       regReadSel,
    input wire       programmedTransfer,
    input wire       byteRequest,
    input wire       seekDone,
    input wire       causeAck,
    input wire       cmdStart,
    input wire [2:0] opState,
    input wire [3:0] irqCause,
    input wire       eClockStyle
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    // ------------------------------
    // Host access starts
    // ------------------------------
    sequence wrRise;
        $rose(writeStrobeN) && !chipSelectN && !eClockStyle;
    endsequence
    // Grant reverses the meaning of the direction line
    sequence eRead;
        $rose(eClock) && eClockStyle
            && (!chipSelectN && rwDirection || !transferGrantN && !rwDirection);
    endsequence
    sequence eDmaWrite;
        $rose(eClock) && eClockStyle && !transferGrantN && rwDirection;
    endsequence

    chk_write_taken: assert property (wrRise |-> ##[2:5] regWrite)
        else $error("write strobe rise gave no register write");
    chk_unselected_ignored: assert property (
        $rose(writeStrobeN) && chipSelectN && transferGrantN |-> ##1 !regWrite [*6])
        else $error("unselected strobe caused a write");
    chk_e_read_drive: assert property (eRead |-> ##[2:6] hostDataOe)
        else $error("read on E rise did not drive the bus");
    chk_e_dma_write: assert property (eDmaWrite |-> ##2 !hostDataOe [*5])
        else $error("DMA write drove the data bus");
    chk_irq_push_pull: assert property ($past(rstn) && !eClockStyle &&
        !$past(eClockStyle) |-> irqOe && irqNOut == !$past(|irqCause))
        else $error("strobe style irq pin wrong");
    chk_irq_open_drain: assert property ($past(rstn) && eClockStyle &&
        $past(eClockStyle) |-> !irqNOut && irqOe == $past(|irqCause))
        else $error("open drain irq pin wrong");
    chk_xfer_request: assert property (
        byteRequest && programmedTransfer |=> irqCause[0])
        else $error("byte request not flagged");
    chk_seek_request: assert property (seekDone |=> irqCause[2])
        else $error("seek end not flagged");
    chk_xfer_withdraw: assert property ((regWrite && regWriteSel || regRead
        && regReadSel) && !byteRequest && !$past(byteRequest) |=> !irqCause[0])
        else $error("data access left transfer request set");
    chk_ack_clears: assert property (causeAck && !seekDone |=> !irqCause[2])
        else $error("cause query did not clear seek flag");
    chk_exec_entry: assert property (cmdStart |=> opState == 3'b100)
        else $error("command start did not enter execution");
    chk_state_onehot: assert property ($onehot(opState))
        else $error("operating state not one-hot");
endmodule

bind fhbi_host_port fhbi_host_port_properties CHK (
    .clk, .rstn, .chipSelectN, .writeStrobeN, .eClock, .rwDirection,
    .transferGrantN, .hostDataOe, .irqNOut, .irqOe, .regWrite, .regWriteSel,
    .regRead, .regReadSel, .programmedTransfer, .byteRequest, .seekDone,
    .causeAck, .cmdStart, .opState, .irqCause, .eClockStyle
);

// ===== fhbi_host_model.sv
// Host processor with its DMA engine, driving the controller's bus pins.
// Assumes the bench merges busDrive with the controller's read data.
`timescale 1ns/1ps

module fhbi_host_model (
    input  wire       clk,
    input  wire [7:0] hostDataOut,
    output reg        busStyleSelect,
    output reg        chipSelectN,
    output reg        registerSelect,
    output reg        readStrobeN,
    output reg        writeStrobeN,
    output reg        eClock,
    output reg        rwDirection,
    output reg        transferGrantN,
    output reg  [7:0] busDrive
);
    initial begin
        busStyleSelect = 1'b0;
        chipSelectN = 1'b1;
        registerSelect = 1'b0;
        readStrobeN = 1'b1;
        writeStrobeN = 1'b1;
        eClock = 1'b0;
        rwDirection = 1'b1;
        transferGrantN = 1'b1;
        busDrive = 8'h00;
    end

    // ------------------------------
    // One transfer: sel 0 processor, 1 DMA grant, 2 none
    // ------------------------------
    task access(input [1:0] sel, input wr, input rs, input late,
                input [7:0] wd, output [7:0] rd);
        begin
            @(posedge clk) #1;
            chipSelectN = (sel != 2'd0) || late;
            transferGrantN = (sel != 2'd1);
            registerSelect = rs;
            if (wr)
                busDrive = wd;
            if (!busStyleSelect) begin
                readStrobeN = wr;
                writeStrobeN = !wr;
                repeat (3) @(posedge clk);
                #1 chipSelectN = (sel != 2'd0);
                // Long low phase plays the part of inserted wait states
                repeat (5) @(posedge clk);
                rd = hostDataOut;
                #1 readStrobeN = 1'b1;
                writeStrobeN = 1'b1;
            end else begin
                rwDirection = (sel == 2'd1) ? wr : !wr;
                @(posedge clk) #1 eClock = 1'b1;
                repeat (7) @(posedge clk);
                rd = hostDataOut;
                #1 eClock = 1'b0;
            end
            // Hold select and data until the synchronised edge is past
            repeat (5) @(posedge clk);
            #1 chipSelectN = 1'b1;
            transferGrantN = 1'b1;
            busDrive = ~busDrive;
        end
    endtask
endmodule

// ===== fhbi_host_port_tb.sv
// Self-checking bench for the controller's host port.
// Assumes the host model drives the pins and the bench plays the core.
`timescale 1ns/1ps

module fhbi_host_port_tb;
    // Row: core pulses {byte,term,seek,ack,sleep,start,done}, causes, state
    localparam [139:0] caseTable = {14'h2009, 14'h1019, 14'h0839, 14'h0c39,
        14'h0419, 14'h011c, 14'h0099, 14'h021a, 14'h011c, 14'h0099};
    reg         clk = 1'b0;
    reg         rstn = 1'b0;
    reg         readyIn = 1'b0;
    reg         programmedTransfer = 1'b1;
    reg         pollStrobe = 1'b0;
    reg  [1:0]  pollDrive = 2'h0;
    reg  [7:0]  statusByte = 8'h5a;
    reg  [7:0]  readByte = 8'hc3;
    reg  [6:0]  ev = 7'h00;
    reg  [9:0]  lastWr;
    reg  [1:0]  lastRd;
    reg  [7:0]  rd;
    reg  [13:0] row;
    wire [7:0]  hostDataOut, writeByte, busDrive;
    wire [2:0]  opState;
    wire [3:0]  irqCause;
    wire        hostDataOe, irqNOut, irqOe, regWrite, regWriteSel, regRead;
    wire        regReadSel, dmaAccess, eClockStyle, busStyleSelect, chipSelectN;
    wire        registerSelect, readStrobeN, writeStrobeN, eClock, rwDirection;
    wire        transferGrantN;
    wire [7:0]  hostDataIn = hostDataOe ? hostDataOut : busDrive;
    // Pull-up outside the controller holds the open-drain line high
    wire        irqLine = irqOe ? irqNOut : 1'b1;
    integer     n_fail = 0;
    integer     n_compared = 0;
    integer     nWr = 0;
    integer     nSeen;
    integer     i;

    always #2 clk = ~clk;

    always @(posedge clk) begin
        if (regWrite) begin
            nWr = nWr + 1;
            lastWr = {dmaAccess, regWriteSel, writeByte};
        end
        if (regRead)
            lastRd = {dmaAccess, regReadSel};
    end

    fhbi_host_port DUT (
        .clk, .rstn, .busStyleSelect, .chipSelectN, .registerSelect, .readStrobeN,
        .writeStrobeN, .eClock, .rwDirection, .transferGrantN, .hostDataIn,
        .hostDataOut, .hostDataOe, .irqNOut, .irqOe, .readyIn, .statusByte,
        .readByte, .regWrite, .regWriteSel, .writeByte, .regRead, .regReadSel,
        .dmaAccess, .programmedTransfer, .byteRequest(ev[6]), .rwTerminate(ev[5]),
        .seekDone(ev[4]), .pollStrobe, .pollDrive, .causeAck(ev[3]),
        .sleepCmd(ev[2]), .cmdStart(ev[1]), .cmdDone(ev[0]), .opState,
        .irqCause, .eClockStyle
    );
    fhbi_host_model HOST (
        .clk, .hostDataOut, .busStyleSelect, .chipSelectN, .registerSelect,
        .readStrobeN, .writeStrobeN, .eClock, .rwDirection, .transferGrantN,
        .busDrive
    );

    // ------------------------------
    // Helpers
    // ------------------------------
    task check(input string what, input [15:0] seen, input [15:0] exp);
        begin
            n_compared = n_compared + 1;
            if (seen !== exp) begin
                n_fail = n_fail + 1;
                $display("wrong value %0s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    task fire(input [6:0] v);
        begin
            @(posedge clk) #1 ev = v;
            @(posedge clk) #1 ev = 7'h00;
            repeat (2) @(posedge clk);
            #1;
        end
    endtask
    task poll(input [1:0] d);
        begin
            @(posedge clk) #1 pollDrive = d;
            pollStrobe = 1'b1;
            @(posedge clk) #1 pollStrobe = 1'b0;
            repeat (3) @(posedge clk);
            #1;
        end
    endtask
    task do_reset;
        begin
            rstn = 1'b0;
            repeat (10) @(posedge clk);
            #1 check("reset", {regWrite, regRead, hostDataOe, irqNOut, irqOe, opState,
                irqCause, eClockStyle}, 16'h0220);
            rstn = 1'b1;
            repeat (5) @(posedge clk);
            #1;
        end
    endtask
    task results;
        begin
            $display("compared %0d mismatched %0d", n_compared, n_fail);
            if (n_fail == 0 && n_compared > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask

    initial begin
        #80000;
        n_fail = n_fail + 1;
        results;
    end

    initial begin
        do_reset;
        for (i = 0; i < 10; i = i + 1) begin
            row = caseTable[(9 - i) * 14 +: 14];
            fire(row[13:7]);
            check("cause", irqCause, row[6:3]);
            check("state", opState, row[2:0]);
            check("irq line", irqLine, !(|row[6:3]));
        end
        $display("test core events done");
        readyIn = 1'b1;
        repeat (4) @(posedge clk);
        poll(2'd2);
        check("ready new", irqCause[3], 1'b1);
        fire(7'h08);
        poll(2'd2);
        check("ready same", irqCause[3], 1'b0);
        poll(2'd1);
        check("ready other", irqCause[3], 1'b1);
        fire(7'h08);
        $display("test ready watch done");
        HOST.access(2'd0, 1'b1, 1'b1, 1'b0, 8'ha5, rd);
        check("write", lastWr, 10'h1a5);
        check("xfer cause", irqCause[0], 1'b0);
        nSeen = nWr;
        HOST.access(2'd2, 1'b1, 1'b1, 1'b0, 8'h3c, rd);
        check("unselected", nWr, nSeen);
        HOST.access(2'd0, 1'b0, 1'b0, 1'b1, 8'h00, rd);
        check("late status", {lastRd, rd}, {2'b00, statusByte});
        HOST.access(2'd0, 1'b0, 1'b1, 1'b0, 8'h00, rd);
        check("data read", {irqCause[1], rd}, {1'b0, readByte});
        HOST.access(2'd1, 1'b1, 1'b0, 1'b0, 8'h96, rd);
        check("dma write", lastWr, 10'h396);
        HOST.access(2'd1, 1'b0, 1'b0, 1'b0, 8'h00, rd);
        check("dma read", {lastRd, rd}, {2'b11, readByte});
        $display("test strobe bus done");
        HOST.busStyleSelect = 1'b1;
        do_reset;
        check("strap", {eClockStyle, irqLine, irqOe}, 3'b110);
        fire(7'h10);
        check("open drain", {irqNOut, irqOe, irqLine}, 3'b010);
        HOST.access(2'd0, 1'b1, 1'b1, 1'b0, 8'h69, rd);
        check("e write", lastWr, 10'h169);
        HOST.access(2'd0, 1'b0, 1'b0, 1'b0, 8'h00, rd);
        check("e status", {lastRd, rd}, {2'b00, statusByte});
        HOST.access(2'd1, 1'b1, 1'b0, 1'b0, 8'h17, rd);
        check("e dma write", lastWr, 10'h317);
        HOST.access(2'd1, 1'b0, 1'b1, 1'b0, 8'h00, rd);
        check("e dma read", {lastRd, rd}, {2'b11, readByte});
        fire(7'h08);
        check("irq release", irqLine, 1'b1);
        $display("test e clock bus done");
        results;
    end
endmodule
